/* inc/mev_pkg.sv */
// constants and types for the monitor event notification block
package mev_pkg;
    localparam int NTEMP_DEF = 4;
    localparam int NVOLT_DEF = 5;
    localparam int NFAN_DEF = 3;
    // smbus alert response address, 7-bit form
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    // own slave address default, strap 000
    localparam logic [6:0] OWN_ADDR_DEF = 7'h28;
    // mask bit position in the start/config register
    localparam logic [7:0] CFG_IDX = 8'h21;
    localparam int MASK_BIT = 7;
    localparam int CLK_MHZ = 100;
    // least time the supervisor output stays low after the supply recovers
    localparam int RST_HOLD_NS = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic MASK_RST = 1'b0;
    localparam logic IRQ_RST = 1'b0;
    typedef enum logic [2:0] {
        MEV_CMP = 3'b001,
        MEV_TWO = 3'b010,
        MEV_ONE = 3'b100
    } mev_mode_t;
    typedef enum logic [2:0] {
        MEV_RS_RUN = 3'b001,
        MEV_RS_LOW = 3'b010,
        MEV_RS_HOLD = 3'b100
    } mev_rs_t;
endpackage

/* core/mev_core.sv */
// event notification core: alert line, overtemp, system irq, supply reset
`timescale 1ns/10ps
module mev_core
    import mev_pkg::*;
#(
    parameter int NT = NTEMP_DEF,
    parameter int NV = NVOLT_DEF,
    parameter int NF = NFAN_DEF,
    parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF,
    parameter int RST_CYC = RST_HOLD_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_conv_done,
    input wire logic [NT-1:0] i_temp_over,
    input wire logic [NT-1:0] i_temp_hyst,
    input wire logic [NT-1:0] i_temp_crit,
    input wire logic [NT-1:0] i_diode_open,
    input wire logic [NV-1:0] i_volt_high,
    input wire logic [NV-1:0] i_volt_low,
    input wire logic [NF-1:0] i_fan_over,
    input wire mev_mode_t i_smi_mode,
    input wire logic i_stat_rd,
    input wire logic i_irq_rd_all,
    input wire logic i_mask_clr,
    input wire logic i_ara_rd,
    input wire logic [6:0] i_ara_addr,
    input wire logic i_vcc_low,
    output logic o_alert_o,
    output logic o_alert_oe,
    output logic o_alert_mask,
    output logic [NT-1:0] o_temp_flag,
    output logic [NF-1:0] o_fan_flag,
    output logic [NT-1:0] o_open_flag,
    output logic o_ara_valid,
    output logic [6:0] o_ara_data,
    output logic o_overtemp_out_n,
    output logic o_sys_irq_out_n,
    output logic [NT+NV+NF-1:0] o_irq_pend,
    output logic o_rst_out_n
);
    localparam int CW = $clog2(RST_CYC + 1);
    localparam logic [CW-1:0] RLOAD = CW'(RST_CYC - 1);

    typedef struct packed {
        logic [NT-1:0] t_flag;
        logic [NF-1:0] f_flag;
        logic [NT-1:0] d_flag;
        logic mask;
        logic alert;
        logic ara_vld;
        logic [NT-1:0] hot;
        logic [NT-1:0] t_pend;
        logic [NV-1:0] v_oor;
        logic [NV-1:0] v_pend;
        logic [NF-1:0] f_oor;
        logic [NF-1:0] f_pend;
        logic [NT-1:0] crit;
        logic irq;
        mev_rs_t rs;
        logic [CW-1:0] rcnt;
    } mev_st_t;

    mev_st_t s_q;
    mev_st_t s_d;
    logic counted;
    logic ara_hit;
    logic [NT-1:0] t_ev;
    logic [NV-1:0] v_ev;
    logic [NF-1:0] f_ev;

    always_comb begin
        s_d = s_q;
        t_ev = '0;
        // open-diode flags never count toward the mask
        counted = (|s_q.t_flag) | (|s_q.f_flag);
        // only a device actually pulling the line answers the response read
        ara_hit = i_ara_rd & (i_ara_addr == ARA_ADDR) & s_q.alert;
        // new results win over a read in the same cycle
        s_d.t_flag = (i_stat_rd ? '0 : s_q.t_flag)
            | (i_conv_done ? i_temp_over : '0);
        s_d.f_flag = (i_stat_rd ? '0 : s_q.f_flag)
            | (i_conv_done ? i_fan_over : '0);
        s_d.d_flag = (i_stat_rd ? '0 : s_q.d_flag)
            | (i_conv_done ? i_diode_open : '0);
        if ((i_stat_rd & counted) | ara_hit) begin
            s_d.mask = 1'b1;
        end else if (i_mask_clr) begin
            s_d.mask = 1'b0;
        end
        // pin follows live flags, gated by the mask
        s_d.alert = ~s_d.mask & ((|s_d.t_flag) | (|s_d.f_flag));
        s_d.ara_vld = ara_hit;
        for (int i = 0; i < NT; i++) begin
            if (i_conv_done) begin
                case (i_smi_mode)
                    MEV_CMP: begin
                        s_d.hot[i] = i_temp_over[i] | (s_q.hot[i] & i_temp_hyst[i]);
                        t_ev[i] = s_d.hot[i] & ~s_q.t_pend[i];
                    end
                    MEV_TWO: begin
                        if (~s_q.hot[i] & i_temp_over[i]) begin
                            s_d.hot[i] = 1'b1;
                            t_ev[i] = 1'b1;
                        end else if (s_q.hot[i] & ~i_temp_hyst[i]) begin
                            s_d.hot[i] = 1'b0;
                            t_ev[i] = ~s_q.t_pend[i];
                        end
                    end
                    MEV_ONE: begin
                        if (~s_q.hot[i] & i_temp_over[i]) begin
                            s_d.hot[i] = 1'b1;
                            t_ev[i] = 1'b1;
                        end else if (s_q.hot[i] & ~i_temp_hyst[i]) begin
                            s_d.hot[i] = 1'b0;
                        end
                    end
                    default: begin
                        s_d.hot[i] = 1'b0;
                    end
                endcase
            end
        end
        // voltage: entering an out-of-range state, once cleared
        v_ev = {NV{i_conv_done}} & (i_volt_high | i_volt_low)
            & ~s_q.v_oor & ~s_q.v_pend;
        if (i_conv_done) begin
            s_d.v_oor = i_volt_high | i_volt_low;
            s_d.f_oor = i_fan_over;
        end
        // fan: both the entry and the return count
        f_ev = {NF{i_conv_done}} & (i_fan_over ^ s_q.f_oor) & ~s_q.f_pend;
        s_d.t_pend = (i_irq_rd_all ? '0 : s_q.t_pend) | t_ev;
        s_d.v_pend = (i_irq_rd_all ? '0 : s_q.v_pend) | v_ev;
        s_d.f_pend = (i_irq_rd_all ? '0 : s_q.f_pend) | f_ev;
        s_d.irq = (|s_d.t_pend) | (|s_d.v_pend) | (|s_d.f_pend);
        s_d.crit = i_temp_crit;
        case (s_q.rs)
            MEV_RS_RUN: begin
                if (i_vcc_low) begin
                    s_d.rs = MEV_RS_LOW;
                end
            end
            MEV_RS_LOW: begin
                if (~i_vcc_low) begin
                    s_d.rs = MEV_RS_HOLD;
                    s_d.rcnt = RLOAD;
                end
            end
            MEV_RS_HOLD: begin
                // stretch keeps a short dip from giving a runt pulse
                if (i_vcc_low) begin
                    s_d.rs = MEV_RS_LOW;
                end else if (s_q.rcnt == '0) begin
                    s_d.rs = MEV_RS_RUN;
                end else begin
                    s_d.rcnt = s_q.rcnt - CW'(1);
                end
            end
            default: begin
                s_d.rs = MEV_RS_LOW;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.mask <= MASK_RST;
            s_q.irq <= IRQ_RST;
            s_q.rs <= MEV_RS_HOLD;
            s_q.rcnt <= RLOAD;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_alert_o = 1'b0;
    assign o_alert_oe = s_q.alert;
    assign o_alert_mask = s_q.mask;
    assign o_temp_flag = s_q.t_flag;
    assign o_fan_flag = s_q.f_flag;
    assign o_open_flag = s_q.d_flag;
    assign o_ara_valid = s_q.ara_vld;
    assign o_ara_data = s_q.ara_vld ? OWN_ADDR : 7'h00;
    assign o_overtemp_out_n = ~(|s_q.crit);
    assign o_sys_irq_out_n = ~s_q.irq;
    assign o_irq_pend = {s_q.f_pend, s_q.v_pend, s_q.t_pend};
    assign o_rst_out_n = (s_q.rs == MEV_RS_RUN);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_flag_read;
        i_stat_rd && ((|o_temp_flag) || (|o_fan_flag));
    endsequence
    sequence s_ara_taken;
        i_ara_rd && i_ara_addr == ARA_ADDR && o_alert_oe;
    endsequence

    a_mask_on_read: assert property (
        s_flag_read |=> o_alert_mask && !o_alert_oe)
        else $error("status read did not set the mask");
    a_mask_blocks_alert: assert property (
        o_alert_mask |-> !o_alert_oe)
        else $error("alert driven while masked");
    a_flag_hold: assert property (
        (o_temp_flag[0] && !i_stat_rd) |=> o_temp_flag[0])
        else $error("flag lost without a status read");
    a_flag_set_alert: assert property (
        (i_conv_done && i_temp_over[0] && !o_alert_mask && !i_mask_clr
            && !i_ara_rd && !i_stat_rd) |=> o_temp_flag[0] && o_alert_oe)
        else $error("out of range result did not raise alert");
    a_ara_answer: assert property (
        s_ara_taken |=> o_ara_valid && o_ara_data == OWN_ADDR && o_alert_mask
            ##1 !o_ara_valid)
        else $error("alert response wrong");
    a_release_clear: assert property (
        (i_mask_clr && !i_stat_rd && !i_ara_rd && !i_conv_done
            && o_temp_flag == '0 && o_fan_flag == '0) |=> !o_alert_mask && !o_alert_oe)
        else $error("alert not released");
    a_crit_follow: assert property (
        (|i_temp_crit) |=> !o_overtemp_out_n)
        else $error("overtemp output not low");
    a_cmp_recur: assert property (
        (i_smi_mode == MEV_CMP && i_irq_rd_all ##1 i_conv_done && i_temp_over[0]
            && !i_irq_rd_all) |=> o_irq_pend[0] && !o_sys_irq_out_n)
        else $error("comparator interrupt did not recur");
    a_one_no_fall: assert property (
        (i_smi_mode == MEV_ONE && i_conv_done && i_temp_over == '0
            && o_irq_pend[NT-1:0] == '0) |=> o_irq_pend[NT-1:0] == '0)
        else $error("one-time mode interrupted on falling");
    a_irq_release: assert property (
        (i_irq_rd_all && !i_conv_done) |=> o_sys_irq_out_n)
        else $error("irq not released after status reads");
    a_rst_low: assert property (
        i_vcc_low |=> !o_rst_out_n [*2])
        else $error("reset output not held low");
    a_stat_clears: assert property (
        (i_stat_rd && !i_conv_done) |=> o_temp_flag == '0 && o_fan_flag == '0
            && o_open_flag == '0)
        else $error("status read left a flag set");
    a_open_no_mask: assert property (
        (i_stat_rd && o_temp_flag == '0 && o_fan_flag == '0 && !o_alert_mask
            && !i_ara_rd) |=> !o_alert_mask)
        else $error("mask set by a read without counted flags");
    a_mask_stays: assert property (
        (o_alert_mask && !i_mask_clr) |=> o_alert_mask)
        else $error("mask dropped without a clear");
    a_alert_source: assert property (
        o_alert_oe |-> (|o_temp_flag) || (|o_fan_flag))
        else $error("alert driven with no flag");
    a_ara_refuse: assert property (
        (i_ara_rd && (i_ara_addr != ARA_ADDR || !o_alert_oe)) |=> !o_ara_valid)
        else $error("alert response given when not owed");
    a_crit_release: assert property (
        !(|i_temp_crit) |=> o_overtemp_out_n)
        else $error("overtemp output held low below threshold");
    a_pend_hold: assert property (
        (o_irq_pend[0] && !i_irq_rd_all) |=> o_irq_pend[0])
        else $error("pending interrupt lost without a clear");
    a_cmp_stop: assert property (
        (i_smi_mode == MEV_CMP && i_conv_done && !i_temp_over[0] && !i_temp_hyst[0]
            && !o_irq_pend[0]) |=> !o_irq_pend[0])
        else $error("comparator interrupt below hysteresis");
    a_two_rise: assert property (
        (i_smi_mode == MEV_TWO && i_conv_done && i_temp_over[1] && !s_q.hot[1])
            |=> o_irq_pend[1])
        else $error("two-times rise gave no interrupt");
    a_two_quiet: assert property (
        (i_smi_mode == MEV_TWO && i_conv_done && s_q.hot[1] && i_temp_hyst[1]
            && !o_irq_pend[1]) |=> !o_irq_pend[1])
        else $error("two-times interrupt above hysteresis");
    a_two_fall: assert property (
        (i_smi_mode == MEV_TWO && i_conv_done && s_q.hot[1] && !i_temp_hyst[1]
            && !o_irq_pend[1]) |=> o_irq_pend[1])
        else $error("two-times fall gave no interrupt");
    a_one_rise: assert property (
        (i_smi_mode == MEV_ONE && i_conv_done && i_temp_over[NT-1] && !s_q.hot[NT-1])
            |=> o_irq_pend[NT-1])
        else $error("one-time rise gave no interrupt");
    a_volt_event: assert property (
        (i_conv_done && i_volt_high[1] && !s_q.v_oor[1] && !o_irq_pend[NT+1])
            |=> o_irq_pend[NT+1])
        else $error("voltage event gave no interrupt");
    a_fan_event: assert property (
        (i_conv_done && i_fan_over[0] != s_q.f_oor[0] && !o_irq_pend[NT+NV])
            |=> o_irq_pend[NT+NV])
        else $error("fan change gave no interrupt");
    a_rst_recover: assert property (
        (s_q.rs == MEV_RS_HOLD && s_q.rcnt == '0 && !i_vcc_low)
            |=> o_rst_out_n)
        else $error("reset output not released after the stretch");
endmodule

/* tb/mev_host.sv */
// host model issuing status reads, irq reads, mask clears and alert-response reads
`timescale 1ns/10ps
module mev_host (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [1:0] i_op,
    input wire logic [6:0] i_addr,
    output logic o_stat_rd = 1'b0,
    output logic o_irq_rd_all = 1'b0,
    output logic o_mask_clr = 1'b0,
    output logic o_ara_rd = 1'b0,
    output logic [6:0] o_ara_addr = 7'h55
);
    // one-cycle command pulses; idle address toggles, so the last value comes back every second cycle
    always @(posedge i_clk) begin
        o_stat_rd <= i_go && i_op == 2'h0;
        o_irq_rd_all <= i_go && i_op == 2'h1;
        o_mask_clr <= i_go && i_op == 2'h2;
        o_ara_rd <= i_go && i_op == 2'h3;
        o_ara_addr <= (i_go && i_op == 2'h3) ? i_addr : ~o_ara_addr;
    end
endmodule

/* tb/tb.sv */
// self-checking bench for the event notification core
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    import mev_pkg::*;
    localparam int RC = 3;
    logic i_clk = 0, i_sys_rst = 1, i_conv_done = 0, i_vcc_low = 0, go = 0;
    logic [3:0] i_temp_over = 0, i_temp_hyst = 0, i_temp_crit = 0, i_diode_open = 0;
    logic [4:0] i_volt_high = 0, i_volt_low = 0;
    logic [2:0] i_fan_over = 0, o_fan_flag;
    logic [1:0] op = 0;
    logic [6:0] adr = 0, i_ara_addr, o_ara_data;
    mev_mode_t i_smi_mode = MEV_CMP;
    logic i_stat_rd, i_irq_rd_all, i_mask_clr, i_ara_rd, o_alert_o, o_alert_oe;
    logic o_alert_mask, o_ara_valid, o_overtemp_out_n, o_sys_irq_out_n, o_rst_out_n;
    logic [3:0] o_temp_flag, o_open_flag;
    logic [11:0] o_irq_pend;
    int fail_count = 0, check_count = 0;
    always #5 i_clk = ~i_clk;
    mev_core #(.RST_CYC(RC)) uut (.i_clk, .i_sys_rst, .i_conv_done, .i_temp_over,
        .i_temp_hyst, .i_temp_crit, .i_diode_open, .i_volt_high, .i_volt_low, .i_fan_over,
        .i_smi_mode, .i_stat_rd, .i_irq_rd_all, .i_mask_clr, .i_ara_rd, .i_ara_addr,
        .i_vcc_low, .o_alert_o, .o_alert_oe, .o_alert_mask, .o_temp_flag, .o_fan_flag,
        .o_open_flag, .o_ara_valid, .o_ara_data, .o_overtemp_out_n, .o_sys_irq_out_n,
        .o_irq_pend, .o_rst_out_n);
    mev_host host (.i_clk, .i_go(go), .i_op(op), .i_addr(adr), .o_stat_rd(i_stat_rd),
        .o_irq_rd_all(i_irq_rd_all), .o_mask_clr(i_mask_clr), .o_ara_rd(i_ara_rd),
        .o_ara_addr(i_ara_addr));
    task automatic cyc(int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic rst_all(mev_mode_t m);
        i_sys_rst = 1;
        i_smi_mode = m;
        {i_temp_over, i_temp_hyst, i_diode_open, i_volt_high, i_fan_over} = '0;
        cyc(4);
        i_sys_rst = 0;
    endtask
    task automatic conv();
        i_conv_done = 1;
        cyc();
        i_conv_done = 0;
    endtask
    // host command: one cycle into the model, one more until the core has taken it
    task automatic hc(logic [1:0] o, logic [6:0] a = 7'h00);
        go = 1;
        op = o;
        adr = a;
        cyc();
        go = 0;
        cyc();
    endtask
    task automatic t_alert();
        rst_all(MEV_CMP);
        i_temp_over = 4'h1;
        conv();
        `CHK("oe", 1'b1, o_alert_oe)
        `CHK("odata", 1'b0, o_alert_o)
        `CHK("flag", 4'h1, o_temp_flag)
        hc(0);
        `CHK("mask", 1'b1, o_alert_mask)
        `CHK("flagclr", 4'h0, o_temp_flag)
        conv();
        `CHK("reflag", 4'h1, o_temp_flag)
        `CHK("masked", 1'b0, o_alert_oe)
        hc(2);
        `CHK("unmask", 1'b0, o_alert_mask)
        `CHK("realert", 1'b1, o_alert_oe)
        i_temp_over = 0;
        hc(0);
        hc(2);
        `CHK("release", 1'b0, o_alert_oe)
        `CHK("flagrel", 4'h0, o_temp_flag)
        i_diode_open = 4'h2;
        conv();
        `CHK("open", 4'h2, o_open_flag)
        hc(0);
        `CHK("openmask", 1'b0, o_alert_mask)
    endtask
    task automatic t_ara();
        rst_all(MEV_CMP);
        i_temp_over = 4'h4;
        conv();
        hc(3, 7'h0d);
        `CHK("arabad", 1'b0, o_ara_valid | o_alert_mask)
        hc(3, ARA_ADDR);
        `CHK("araval", 1'b1, o_ara_valid)
        `CHK("aradat", OWN_ADDR_DEF, o_ara_data)
        `CHK("aramask", 2'b10, {o_alert_mask, o_alert_oe})
        cyc();
        `CHK("araend", 1'b0, o_ara_valid)
        hc(3, ARA_ADDR);
        `CHK("aralow", 2'b00, {o_ara_valid, o_alert_oe})
    endtask
    task automatic overtemp_out_n();
        i_temp_crit = 4'h8;
        cyc();
        `CHK("crit", 1'b0, o_overtemp_out_n)
        cyc(3);
        `CHK("crithold", 1'b0, o_overtemp_out_n)
        i_temp_crit = 0;
        cyc();
        `CHK("critrel", 1'b1, o_overtemp_out_n)
    endtask
    task automatic t_cmp();
        rst_all(MEV_CMP);
        {i_temp_over, i_temp_hyst} = 8'h11;
        conv();
        `CHK("cmp1", 2'b10, {o_irq_pend[0], o_sys_irq_out_n})
        conv();
        `CHK("cmpheld", 12'h001, o_irq_pend)
        hc(1);
        `CHK("cmpclr", 2'b01, {o_irq_pend[0], o_sys_irq_out_n})
        conv();
        `CHK("cmpagain", 12'h001, o_irq_pend)
        hc(1);
        i_temp_over = 0;
        conv();
        `CHK("cmprecur", 12'h001, o_irq_pend)
        hc(1);
        i_temp_hyst = 0;
        conv();
        `CHK("cmpstop", 12'h000, o_irq_pend)
    endtask
    task automatic t_two();
        rst_all(MEV_TWO);
        {i_temp_over, i_temp_hyst} = 8'h22;
        conv();
        `CHK("two1", 12'h002, o_irq_pend)
        hc(1);
        i_temp_over = 0;
        conv();
        `CHK("twoquiet", 12'h000, o_irq_pend)
        i_temp_hyst = 0;
        conv();
        `CHK("twofall", 12'h002, o_irq_pend)
    endtask
    task automatic t_one();
        rst_all(MEV_ONE);
        {i_temp_over, i_temp_hyst} = 8'h88;
        conv();
        `CHK("one1", 12'h008, o_irq_pend)
        hc(1);
        {i_temp_over, i_temp_hyst} = 8'h00;
        conv();
        `CHK("onefall", 12'h000, o_irq_pend)
        {i_temp_over, i_temp_hyst} = 8'h88;
        conv();
        `CHK("onerise", 12'h008, o_irq_pend)
    endtask
    task automatic t_volt_fan();
        rst_all(MEV_CMP);
        i_volt_high = 5'h02;
        i_volt_low = 5'h10;
        conv();
        `CHK("volt", 12'h120, o_irq_pend)
        hc(1);
        i_fan_over = 3'h1;
        conv();
        `CHK("fan", 12'h200, o_irq_pend)
        `CHK("fanflag", 3'h1, o_fan_flag)
        hc(1);
        i_fan_over = 0;
        conv();
        `CHK("fanexit", 12'h200, o_irq_pend)
        i_volt_low = 0;
    endtask
    task automatic t_supply();
        rst_all(MEV_CMP);
        cyc(RC + 2);
        `CHK("rstup", 1'b1, o_rst_out_n)
        i_vcc_low = 1;
        cyc();
        `CHK("rstlow", 1'b0, o_rst_out_n)
        cyc(5);
        i_vcc_low = 0;
        cyc(RC);
        `CHK("rsthold", 1'b0, o_rst_out_n)
        cyc(1);
        `CHK("rstrel", 1'b1, o_rst_out_n)
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // whole run is about a hundred cycles; generous margin
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    initial begin
        t_alert();
        t_ara();
        overtemp_out_n();
        t_cmp();
        t_two();
        t_one();
        t_volt_fan();
        t_supply();
        give_verdict();
    end
endmodule
